// ### rtl/sctd_cfg.svh
// Constants for the spacecraft time distribution block.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef SCTD_CFG_SVH
`define SCTD_CFG_SVH
`define SCTD_COARSE_W    32
`define SCTD_FINE_W      24
`define SCTD_FINE_IMPL   16
`define SCTD_DAY_W       16
`define SCTD_MS_W        32
`define SCTD_SUBMS_W     16
`define SCTD_SUBMS_IMPL  1'b0
`define SCTD_CLK_HZ      40000000
`define SCTD_MS_HZ       1000
`define SCTD_MS_CYC      (`SCTD_CLK_HZ / `SCTD_MS_HZ)
`define SCTD_MS_PER_DAY  32'h0526_5C00
`define SCTD_TTYPE_MIN   8'h01
`define SCTD_TTYPE_MAX   8'hF0
`define SCTD_CNT_W       16
`endif

// ### rtl/sctd_pkg.sv
// Types for the spacecraft time distribution block.
// Assumes sctd_cfg.svh is on the include path.
`include "sctd_cfg.svh"
package sctd_pkg;
    typedef enum logic [1:0] {
        SCTD_IDLE,
        SCTD_WAIT_SYNC,
        SCTD_SEND
    } sctd_tx_e;
endpackage

// ### rtl/sctd_ms_tick.sv
// Millisecond enable divider for the civil time counter.
// Assumes one clock mclk and asynchronous active-low reset.
`timescale 1ns/1ps
`include "sctd_cfg.svh"
module sctd_ms_tick (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic clr,
    output logic      tick
);
    logic [`SCTD_CNT_W-1:0] cnt_q;
    logic [`SCTD_CNT_W-1:0] cnt_d;
    wire                    at_end = (cnt_q == `SCTD_CNT_W'(`SCTD_MS_CYC - 1));
    assign cnt_d = (clr || at_end) ? '0 : cnt_q + `SCTD_CNT_W'(1);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= at_end && !clr;
        end
    end
endmodule // sctd_ms_tick

// ### rtl/sctd_time_core.sv
// Local time keeping, SYNC capture and time message build.
// Assumes a CAN controller reports SYNC tx/rx success as async levels
// and delivers object writes as one-cycle strobes on mclk.
`timescale 1ns/1ps
`include "sctd_cfg.svh"
module sctd_time_core (
    input  wire logic                      mclk,
    input  wire logic                      arst_n,
    input  wire logic                      is_producer,
    input  wire logic                      is_sync_producer,
    input  wire logic [7:0]                trans_type,
    input  wire logic                      sync_tx_done,
    input  wire logic                      sync_rx_done,
    input  wire logic                      et_wr,
    input  wire logic [`SCTD_COARSE_W-1:0] et_wr_coarse,
    input  wire logic [`SCTD_FINE_W-1:0]   et_wr_fine,
    input  wire logic                      ct_wr,
    input  wire logic [`SCTD_DAY_W-1:0]    ct_wr_day,
    input  wire logic [`SCTD_MS_W-1:0]     ct_wr_ms,
    input  wire logic [`SCTD_SUBMS_W-1:0]  ct_wr_subms,
    input  wire logic                      mt_rx,
    input  wire logic [`SCTD_COARSE_W-1:0] mt_rx_coarse,
    input  wire logic [`SCTD_FINE_W-1:0]   mt_rx_fine,
    input  wire logic                      msg_ack,
    output logic [`SCTD_COARSE_W-1:0]      et_rd_coarse,
    output logic [`SCTD_FINE_W-1:0]        et_rd_fine,
    output logic [`SCTD_DAY_W-1:0]         ct_rd_day,
    output logic [`SCTD_MS_W-1:0]          ct_rd_ms,
    output logic [`SCTD_SUBMS_W-1:0]       ct_rd_subms,
    output logic [`SCTD_COARSE_W-1:0]      msg_coarse,
    output logic [`SCTD_FINE_W-1:0]        msg_fine,
    output logic [`SCTD_DAY_W-1:0]         msg_day,
    output logic [`SCTD_MS_W-1:0]          msg_ms,
    output logic [`SCTD_SUBMS_W-1:0]       msg_subms,
    output logic                           msg_master,
    output logic                           msg_valid,
    output logic                           sync_ind,
    output logic                           cfg_err
);
    localparam int FI = `SCTD_FINE_IMPL;
    localparam int FU = `SCTD_FINE_W - `SCTD_FINE_IMPL;

    // ------------------------------------------------------------
    // SYNC event synchronisers
    // ------------------------------------------------------------
    logic [2:0] stx_q;
    logic [2:0] srx_q;
    logic       stx_lvl_q;
    logic       srx_lvl_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stx_q     <= '0;
            srx_q     <= '0;
            stx_lvl_q <= 1'b0;
            srx_lvl_q <= 1'b0;
        end else begin
            stx_q <= {stx_q[1:0], sync_tx_done};
            srx_q <= {srx_q[1:0], sync_rx_done};
            if (stx_q[1] == stx_q[2]) stx_lvl_q <= stx_q[2];
            if (srx_q[1] == srx_q[2]) srx_lvl_q <= srx_q[2];
        end
    end
    // Agreed-level change filters glitches on a single sample
    wire stx_agree = (stx_q[1] == stx_q[2]);
    wire srx_agree = (srx_q[1] == srx_q[2]);
    wire stx_ev    = stx_agree && stx_q[2] && !stx_lvl_q;
    wire srx_ev    = srx_agree && srx_q[2] && !srx_lvl_q;
    // Producer samples on its own SYNC transmit; consumer on receipt
    wire sync_ev   = is_producer ? stx_ev : srx_ev;

    // ------------------------------------------------------------
    // Elapsed time counter
    // ------------------------------------------------------------
    logic [`SCTD_COARSE_W-1:0] coarse_q;
    logic [`SCTD_COARSE_W-1:0] coarse_d;
    logic [FI-1:0]             fine_q;
    logic [FI-1:0]             fine_d;
    wire  fine_wrap = &fine_q;
    // Consumers take the master time as a write of their own local time
    wire  ld_ext   = !is_producer && mt_rx;
    wire  ld_et    = et_wr || ld_ext;
    // Low fine bits of incoming values are dropped here
    wire  [FI-1:0] ld_fine = ld_ext ? mt_rx_fine[`SCTD_FINE_W-1 -: FI]
                                    : et_wr_fine[`SCTD_FINE_W-1 -: FI];
    wire  [`SCTD_COARSE_W-1:0] ld_coarse = ld_ext ? mt_rx_coarse : et_wr_coarse;
    assign fine_d   = ld_et ? ld_fine : fine_q + FI'(1);
    assign coarse_d = ld_et ? ld_coarse
                    : (fine_wrap ? coarse_q + `SCTD_COARSE_W'(1) : coarse_q);
    wire  [`SCTD_FINE_W-1:0] fine_full = {fine_q, {FU{1'b0}}};

    // ------------------------------------------------------------
    // Civil time counter
    // ------------------------------------------------------------
    logic                      ms_tick;
    logic [`SCTD_DAY_W-1:0]    day_q;
    logic [`SCTD_DAY_W-1:0]    day_d;
    logic [`SCTD_MS_W-1:0]     ms_q;
    logic [`SCTD_MS_W-1:0]     ms_d;
    sctd_ms_tick u_ms (
        .mclk   (mclk),
        .arst_n (arst_n),
        .clr    (ct_wr),
        .tick   (ms_tick)
    );
    wire day_end = (ms_q >= `SCTD_MS_PER_DAY - `SCTD_MS_W'(1));
    assign ms_d  = ct_wr ? ct_wr_ms
                 : (ms_tick ? (day_end ? '0 : ms_q + `SCTD_MS_W'(1)) : ms_q);
    assign day_d = ct_wr ? ct_wr_day
                 : ((ms_tick && day_end) ? day_q + `SCTD_DAY_W'(1) : day_q);
    // No sub-ms counter: written sub-ms bits are don't-care, read as zero
    wire [`SCTD_SUBMS_W-1:0] subms_v = `SCTD_SUBMS_IMPL ? ct_wr_subms : '0;

    // ------------------------------------------------------------
    // Snapshot and message handshake
    // ------------------------------------------------------------
    sctd_pkg::sctd_tx_e st_q;
    sctd_pkg::sctd_tx_e st_d;
    // Synchronous types only; also refuse when this node both produces time and issues SYNC
    wire tt_ok  = (trans_type >= `SCTD_TTYPE_MIN) && (trans_type <= `SCTD_TTYPE_MAX);
    wire cfg_ok = tt_ok && !(is_producer && is_sync_producer);
    always_comb begin
        st_d = st_q;
        case (st_q)
            sctd_pkg::SCTD_IDLE:      if (cfg_ok) st_d = sctd_pkg::SCTD_WAIT_SYNC;
            // A SYNC that meets a config fault must not send a stale snapshot
            sctd_pkg::SCTD_WAIT_SYNC: if (sync_ev && cfg_ok) st_d = sctd_pkg::SCTD_SEND;
                                      else if (!cfg_ok) st_d = sctd_pkg::SCTD_IDLE;
            sctd_pkg::SCTD_SEND:      if (msg_ack) st_d = sctd_pkg::SCTD_WAIT_SYNC;
            default:                  st_d = sctd_pkg::SCTD_IDLE;
        endcase
    end
    // A new SYNC while sending refreshes the snapshot; the older one is lost
    wire snap = sync_ev && cfg_ok;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            coarse_q <= '0;
            fine_q   <= '0;
            day_q    <= '0;
            ms_q     <= '0;
            st_q     <= sctd_pkg::SCTD_IDLE;
        end else begin
            coarse_q <= coarse_d;
            fine_q   <= fine_d;
            day_q    <= day_d;
            ms_q     <= ms_d;
            st_q     <= st_d;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            et_rd_coarse <= '0;
            et_rd_fine   <= '0;
            ct_rd_day    <= '0;
            ct_rd_ms     <= '0;
            ct_rd_subms  <= '0;
            msg_coarse   <= '0;
            msg_fine     <= '0;
            msg_day      <= '0;
            msg_ms       <= '0;
            msg_subms    <= '0;
            msg_master   <= 1'b0;
            msg_valid    <= 1'b0;
            sync_ind     <= 1'b0;
            cfg_err      <= 1'b0;
        end else begin
            et_rd_coarse <= coarse_q;
            et_rd_fine   <= fine_full;
            ct_rd_day    <= day_q;
            ct_rd_ms     <= ms_q;
            ct_rd_subms  <= subms_v;
            if (snap) begin
                msg_coarse <= coarse_q;
                msg_fine   <= fine_full;
                msg_day    <= day_q;
                msg_ms     <= ms_q;
                msg_subms  <= subms_v;
                msg_master <= is_producer;
            end
            msg_valid <= (st_d == sctd_pkg::SCTD_SEND);
            sync_ind  <= stx_ev || srx_ev;
            cfg_err   <= !cfg_ok;
        end
    end
endmodule // sctd_time_core

// ### sim/sctd_time_core_asserts.sv
// Port checker for sctd_time_core, bound below.
// Assumes one clock domain, mclk, with arst_n.
`timescale 1ns/1ps
module sctd_core_chk (
    input wire logic mclk, arst_n, is_producer, is_sync_producer, et_wr, mt_rx, msg_ack,
    input wire logic msg_master, msg_valid, sync_ind, cfg_err,
    input wire logic [7:0] trans_type,
    input wire logic [31:0] et_wr_coarse, et_rd_coarse, msg_coarse,
    input wire logic [23:0] et_wr_fine, et_rd_fine, msg_fine,
    input wire logic [15:0] ct_rd_subms, msg_subms
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire        ld  = et_wr | (mt_rx & ~is_producer);
    wire        bad = trans_type == 8'h00 || trans_type > 8'hF0 || (is_producer & is_sync_producer);
    wire [15:0] wf  = et_wr_fine[23:8];
    wire [47:0] rd  = {et_rd_coarse, et_rd_fine[23:8]};
    a_fine_zero: assert property (et_rd_fine[7:0] == 8'h00 && msg_fine[7:0] == 8'h00)
        else $error("fine low bits set");
    a_subms_zero: assert property (ct_rd_subms == 16'h0000 && msg_subms == 16'h0000)
        else $error("sub-ms bits set");
    a_et_load: assert property (et_wr && !(mt_rx && !is_producer) |-> ##2
        et_rd_coarse == $past(et_wr_coarse, 2) && et_rd_fine[23:8] == $past(wf, 2))
        else $error("write not read back");
    a_count_step: assert property ($past(arst_n, 4) && !$past(ld, 2) |->
        rd == $past(rd) + 48'h1) else $error("time not counting");
    a_snap_match: assert property (sync_ind && msg_valid |->
        msg_coarse == et_rd_coarse && msg_fine == et_rd_fine) else $error("snapshot off");
    a_ind_pulse: assert property (sync_ind |=> !sync_ind)
        else $error("indication too long");
    a_snap_hold: assert property (!sync_ind |-> $stable(msg_coarse) && $stable(msg_fine))
        else $error("snapshot moved");
    a_ack_clear: assert property (msg_valid && msg_ack |=> !msg_valid || sync_ind)
        else $error("pending after ack");
    a_cfg_flag: assert property ($past(arst_n) |-> cfg_err == $past(bad))
        else $error("config flag wrong");
    a_no_send: assert property (cfg_err && $past(cfg_err) |-> !$rose(msg_valid))
        else $error("sent with bad config");
    a_role_msg: assert property ($rose(msg_valid) |-> sync_ind && msg_master == is_producer)
        else $error("message kind wrong");
    c_prod: cover property (sync_ind && msg_valid && msg_master);
    c_cons: cover property (sync_ind && msg_valid && !msg_master);
    c_bad: cover property (cfg_err && sync_ind);
endmodule // sctd_core_chk
bind sctd_time_core sctd_core_chk u_chk (.mclk, .arst_n, .is_producer, .is_sync_producer,
    .et_wr, .mt_rx, .msg_ack, .msg_master, .msg_valid, .sync_ind, .cfg_err, .trans_type,
    .et_wr_coarse, .et_rd_coarse, .msg_coarse, .et_wr_fine, .et_rd_fine, .msg_fine,
    .ct_rd_subms, .msg_subms);

// ### sim/sctd_can_model.sv
// CAN controller stand-in: SYNC success levels and message take-up.
// Assumes mclk of 25 ns; acts on the falling edge like the bench.
`timescale 1ns/1ps
module sctd_can_model (
    input  wire logic       mclk, msg_valid,
    input  wire logic [3:0] ack_dly,
    output logic            sync_tx_done, sync_rx_done, msg_ack
);
    int wait_n = 0;
    initial {sync_tx_done, sync_rx_done, msg_ack} = 3'b000;
    // Varying take-up delay exercises both prompt and slow CAN sides
    always @(negedge mclk) begin
        msg_ack = msg_valid && !msg_ack && wait_n >= ack_dly;
        wait_n = (msg_valid && !msg_ack) ? wait_n + 1 : 0;
    end
    // SYNC success level, raised 7 ns after the calling falling edge of mclk, held len cycles
    task automatic sync_pulse(input bit tx, input int len);
        #7;
        if (tx) sync_tx_done = 1'b1;
        else sync_rx_done = 1'b1;
        #(len * 25);
        {sync_tx_done, sync_rx_done} = 2'b00;
    endtask
endmodule // sctd_can_model

// ### sim/tb_top.sv
// Self-checking bench for sctd_time_core with the CAN side model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module tb_top;
    logic        mclk, arst_n, is_producer, is_sync_producer, et_wr, ct_wr, mt_rx;
    logic        sync_tx_done, sync_rx_done, msg_ack, msg_master, msg_valid, sync_ind, cfg_err;
    logic [7:0]  trans_type;
    logic [3:0]  ack_dly;
    logic [31:0] et_wr_coarse, mt_rx_coarse, ct_wr_ms, et_rd_coarse, ct_rd_ms, msg_coarse, msg_ms;
    logic [23:0] et_wr_fine, mt_rx_fine, et_rd_fine, msg_fine;
    logic [15:0] ct_wr_day, ct_wr_subms, ct_rd_day, ct_rd_subms, msg_day, msg_subms;
    int          n_errors, cmp_count, cyc, seed, w, k;
    sctd_time_core uut (.mclk, .arst_n, .is_producer, .is_sync_producer, .trans_type,
        .sync_tx_done, .sync_rx_done, .et_wr, .et_wr_coarse, .et_wr_fine, .ct_wr, .ct_wr_day,
        .ct_wr_ms, .ct_wr_subms, .mt_rx, .mt_rx_coarse, .mt_rx_fine, .msg_ack, .et_rd_coarse,
        .et_rd_fine, .ct_rd_day, .ct_rd_ms, .ct_rd_subms, .msg_coarse, .msg_fine, .msg_day,
        .msg_ms, .msg_subms, .msg_master, .msg_valid, .sync_ind, .cfg_err);
    sctd_can_model pm (.mclk, .msg_valid, .ack_dly, .sync_tx_done, .sync_rx_done, .msg_ack);
    initial begin mclk = 1'b0; forever #12.5 mclk = ~mclk; end
    // Run needs about 40200 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin n_errors++; conclude(); end
    end
    function automatic logic [55:0] et_exp(input logic [31:0] c, input logic [23:0] f, int n);
        logic [47:0] t;
        t = {c, f[23:8]} + 48'(n);
        return {t, 8'h00};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin n_errors++; $display("BAD %0t got %h exp %h", $time, got, exp); end
    endtask
    task automatic tick(input int n); repeat (n) @(negedge mclk); endtask
    task automatic wr_et(input logic [31:0] c, input logic [23:0] f);
        {et_wr, et_wr_coarse, et_wr_fine} = {1'b1, c, f};
        tick(1);
        {et_wr, mt_rx} = 2'b00;
        w = cyc;
    endtask
    task automatic sync_case(input bit p, input bit pin, input bit want);
        logic [31:0] c;
        c = $random(seed);
        is_producer = p;
        ack_dly = $random(seed);
        wr_et(c, 24'h000000);
        // The filter needs two agreeing samples, so a pulse is at least two cycles
        fork pm.sync_pulse(pin, 2 + {$random(seed)} % 5); join_none
        for (k = 0; k < 12 && sync_ind !== 1'b1; k++) tick(1);
        chk(sync_ind, 1'b1);
        chk({msg_valid, msg_master}, {want, want & p});
        if (want) chk({msg_coarse, msg_fine}, et_exp(c, 24'h000000, cyc - w - 1));
        chk({msg_day, msg_ms, msg_subms}, 64'h0);
        for (k = 0; k < 40 && msg_valid !== 1'b0; k++) tick(1);
        chk(msg_valid, 1'b0);
        tick(8);
        $display("test sync done");
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        logic [31:0] c, mc;
        logic [23:0] f, mf;
        logic [7:0]  tts [5];
        tts = '{8'h00, 8'h01, 8'hF0, 8'hF1, 8'hFF};
        seed = 32'h41b6524c;
        {arst_n, is_producer, is_sync_producer, et_wr, ct_wr, mt_rx, ack_dly} = '0;
        {et_wr_coarse, et_wr_fine, mt_rx_coarse, mt_rx_fine, ct_wr_day, ct_wr_ms, ct_wr_subms} = '0;
        {trans_type, n_errors, cmp_count, cyc} = {8'h01, 96'h0};
        repeat (10) @(posedge mclk);
        chk({et_rd_coarse, et_rd_fine, msg_valid, sync_ind, cfg_err}, 64'h0);
        @(negedge mclk) arst_n = 1'b1;
        tick(4);
        // Both load paths at once; the master time path only loads on a consumer
        for (int i = 0; i < 12; i++) begin
            c = (i < 2) ? 32'hFFFF_FFFF : $random(seed);
            f = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h0000FF : $random(seed);
            mc = (i < 2) ? c : $random(seed);
            mf = (i < 2) ? f : $random(seed);
            {is_producer, mt_rx, mt_rx_coarse, mt_rx_fine} = {i[0], 1'b1, mc, mf};
            wr_et(c, f);
            if (!i[0]) {c, f} = {mc, mf};
            tick(1);
            chk({et_rd_coarse, et_rd_fine}, et_exp(c, f, 0));
            tick(1);
            chk({et_rd_coarse, et_rd_fine}, et_exp(c, f, 1));
        end
        $display("test elapsed done");
        for (int i = 0; i < 5; i++) begin
            trans_type = tts[i];
            tick(2);
            chk(cfg_err, tts[i] == 8'h00 || tts[i] > 8'hF0);
        end
        trans_type = 8'h01 + 8'({$random(seed)} % 240);
        sync_case(1'b1, 1'b1, 1'b1);
        sync_case(1'b0, 1'b0, 1'b1);
        sync_case(1'b1, 1'b0, 1'b0);
        sync_case(1'b0, 1'b1, 1'b0);
        {is_producer, is_sync_producer} = 2'b11;
        tick(2);
        chk(cfg_err, 1'b1);
        sync_case(1'b1, 1'b1, 1'b0);
        {is_sync_producer, trans_type} = {1'b0, 8'hF1};
        sync_case(1'b0, 1'b0, 1'b0);
        trans_type = 8'h01;
        {ct_wr, ct_wr_day, ct_wr_ms, ct_wr_subms} = {1'b1, 16'($random(seed)), 32'h0526_5BFF, 16'hA5C3};
        tick(1);
        ct_wr = 1'b0;
        tick(1);
        chk({ct_rd_day, ct_rd_ms, ct_rd_subms}, {ct_wr_day, ct_wr_ms, 16'h0000});
        tick(40010);
        chk({ct_rd_day, ct_rd_ms, ct_rd_subms}, {ct_wr_day + 16'h0001, 48'h0});
        $display("test civil done");
        conclude();
    end
endmodule // tb_top
